// ### hdl/err_irq_defs.vh
// Constants for the error capture and interrupt enable block
`ifndef ERR_IRQ_DEFS_VH
`define ERR_IRQ_DEFS_VH

// Register offsets (byte addresses)
`define OFS_IRQ_STATUS     8'h00
`define OFS_IRQ_ENABLE     8'h04
`define OFS_ERR_HDR0       8'h08
`define OFS_ERR_HDR1       8'h0c
`define OFS_ERR_HDR2       8'h10
`define OFS_ERR_HDR3       8'h14
`define OFS_ERR_FLAGS      8'h18
`define OFS_ERR_ENABLE     8'h1c

// Reset values
`define RST_IRQ_ENABLE     32'h0000_0000
`define RST_ERR_HDR        32'h0000_0000
`define RST_ERR_FLAGS      32'h0000_0000
`define RST_ERR_ENABLE     32'h0000_0000

// Implemented bits and write-one-to-clear status bits
`define ENABLE_MASK        32'h07ff_ffff
`define ERR_MASK           32'h0001_1133
`define STATUS_W1C_MASK    32'h0700_f03f

// Error source bit positions
`define ERR_CA_DETECTED    16
`define ERR_UNEXP_CPL      12
`define ERR_CPL_TIMEOUT    8
`define ERR_RX_CA_CPL      5
`define ERR_RX_UR_CPL      4
`define ERR_TX_CA_CPL      1
`define ERR_TX_UR_CPL      0

// Interrupt field positions
`define IRQ_MSG_RX         5
`define IRQ_SYS_ERR        0

`endif

// ### hdl/err_irq_ctrl.v
// Interrupt enable gating, error header capture and error flag logic
//
// Contract
// RULE1 - Enable bits 20:18 gate extended VC transmit posted, nonposted, completion full.
// RULE2 - Bit 17 enables extended VC receive error interrupt, resets zero.
// RULE3 - Bit 16 enables VC zero receive error interrupt, resets zero.
// RULE4 - Bits 15:12 enable transaction, link, MAC, power management interrupts.
// RULE5 - Bits 11:9 enable VC zero receive full interrupts.
// RULE6 - Bits 8:6 enable VC zero transmit full interrupts.
// RULE7 - Message interrupt gated by its enable and by per-message enable.
// RULE8 - Bits 4:0 enable power-down, correctable, nonfatal, fatal, system error.
// RULE9 - Request reaches interrupt controller only when its enable is set.
// RULE10 - Packet error captures four header doublewords into four registers.
// RULE11 - Header registers read-only, zero after reset until a capture.
// RULE12 - Completer abort detected sets sticky flag, cleared by writing one.
// RULE13 - Unexpected completion sets sticky write-one-to-clear flag.
// RULE14 - Completion timeout sets sticky write-one-to-clear flag.
// RULE15 - Received abort and unsupported completions set flags bits 5 and 4.
// RULE16 - Transmitted abort and unsupported completions set flags bits 1 and 0.
// RULE17 - Reserved bits in error flags and enables read zero.
// RULE18 - Per-flag enable at same position raises system error; enables reset zero.
// RULE19 - Received abort and unsupported enables act independently.
// RULE20 - System error status bit 0 is write-one-to-clear, set by enabled errors.
// RULE21 - Interrupt output is OR of status AND enable, one clock latency.
`timescale 1ns/10ps

`include "err_irq_defs.vh"

module err_irq_ctrl #(
  parameter DATA_W = 32,
  parameter ADDR_W = 8
) (
  input  wire              REF_CLK,
  input  wire              RST_N,
  input  wire              REG_SEL,
  input  wire              REG_WR,
  input  wire [ADDR_W-1:0] REG_ADDR,
  input  wire [DATA_W-1:0] REG_WDATA,
  output reg  [DATA_W-1:0] REG_RDATA,
  input  wire [DATA_W-1:0] SRC_EVENTS,
  input  wire              MSG_TYPE_EN,
  input  wire              PKT_ERR,
  input  wire [DATA_W-1:0] PKT_HDR_DW0,
  input  wire [DATA_W-1:0] PKT_HDR_DW1,
  input  wire [DATA_W-1:0] PKT_HDR_DW2,
  input  wire [DATA_W-1:0] PKT_HDR_DW3,
  input  wire [6:0]        ERR_EVENTS,
  output reg               IRQ_REQ,
  output reg               SYS_ERR_IRQ
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  reg rst_s1_r;
  reg rst_s2_r;

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  wire rst_n = rst_s2_r;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg  [DATA_W-1:0] irq_enable_r;
  reg  [DATA_W-1:0] irq_status_r;
  reg  [DATA_W-1:0] err_flags_r;
  reg  [DATA_W-1:0] err_enable_r;
  reg  [DATA_W-1:0] hdr_r [0:3];
  reg  [DATA_W-1:0] irq_status_nxt;
  reg  [DATA_W-1:0] err_flags_nxt;
  reg  [DATA_W-1:0] err_set;
  reg  [DATA_W-1:0] rdata_nxt;
  wire [DATA_W-1:0] hdr_in [0:3];
  wire              wr_en;
  wire              sys_err_set;
  wire              irq_nxt;

  assign wr_en     = REG_SEL & REG_WR;
  assign hdr_in[0] = PKT_HDR_DW0;
  assign hdr_in[1] = PKT_HDR_DW1;
  assign hdr_in[2] = PKT_HDR_DW2;
  assign hdr_in[3] = PKT_HDR_DW3;

  // ----------------------------------------------------------------
  // Enable register
  // ----------------------------------------------------------------
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable_r <= `RST_IRQ_ENABLE;                       // [RULE2] [RULE3] [RULE4]
    end else if (wr_en && REG_ADDR == `OFS_IRQ_ENABLE) begin
      irq_enable_r <= REG_WDATA & `ENABLE_MASK;             // [RULE1] [RULE5] [RULE6] [RULE8]
    end
  end

  // ----------------------------------------------------------------
  // Error flags and enables
  // ----------------------------------------------------------------
  always @* begin
    err_set                     = {DATA_W{1'b0}};
    err_set[`ERR_CA_DETECTED]   = ERR_EVENTS[6];            // [RULE12]
    err_set[`ERR_UNEXP_CPL]     = ERR_EVENTS[5];            // [RULE13]
    err_set[`ERR_CPL_TIMEOUT]   = ERR_EVENTS[4];            // [RULE14]
    err_set[`ERR_RX_CA_CPL]     = ERR_EVENTS[3];            // [RULE15]
    err_set[`ERR_RX_UR_CPL]     = ERR_EVENTS[2];            // [RULE15]
    err_set[`ERR_TX_CA_CPL]     = ERR_EVENTS[1];            // [RULE16]
    err_set[`ERR_TX_UR_CPL]     = ERR_EVENTS[0];            // [RULE16]
    err_flags_nxt = err_flags_r;
    if (wr_en && REG_ADDR == `OFS_ERR_FLAGS) begin
      err_flags_nxt = err_flags_nxt & ~REG_WDATA;
    end
    // Set wins over a simultaneous clear
    err_flags_nxt = (err_flags_nxt | err_set) & `ERR_MASK;   // [RULE17]
  end

  // Only a new event raises system error, per same-position enable
  assign sys_err_set = |(err_set & err_enable_r);            // [RULE18] [RULE19]

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      err_flags_r  <= `RST_ERR_FLAGS;
      err_enable_r <= `RST_ERR_ENABLE;                       // [RULE18]
    end else begin
      err_flags_r <= err_flags_nxt;
      if (wr_en && REG_ADDR == `OFS_ERR_ENABLE) begin
        err_enable_r <= REG_WDATA & `ERR_MASK;               // [RULE17]
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  always @* begin
    irq_status_nxt = irq_status_r;
    if (wr_en && REG_ADDR == `OFS_IRQ_STATUS) begin
      irq_status_nxt = irq_status_nxt & ~(REG_WDATA & `STATUS_W1C_MASK);
    end
    // Sticky sources set over a clear; level sources follow inputs
    irq_status_nxt = (irq_status_nxt & `STATUS_W1C_MASK) | (SRC_EVENTS & `STATUS_W1C_MASK)
                     | (SRC_EVENTS & ~`STATUS_W1C_MASK & `ENABLE_MASK);
    irq_status_nxt[`IRQ_MSG_RX] = irq_status_nxt[`IRQ_MSG_RX] & ~(SRC_EVENTS[`IRQ_MSG_RX] & ~MSG_TYPE_EN)
                                  | (irq_status_r[`IRQ_MSG_RX] & ~(wr_en && REG_ADDR == `OFS_IRQ_STATUS
                                  && REG_WDATA[`IRQ_MSG_RX]));  // [RULE7]
    irq_status_nxt[`IRQ_SYS_ERR] = irq_status_nxt[`IRQ_SYS_ERR] | sys_err_set;  // [RULE20]
  end

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_r <= {DATA_W{1'b0}};
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Error header capture
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_hdr
      always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
          hdr_r[gi] <= `RST_ERR_HDR;                         // [RULE11]
        end else if (PKT_ERR) begin
          hdr_r[gi] <= hdr_in[gi];                           // [RULE10]
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupt outputs
  // ----------------------------------------------------------------
  assign irq_nxt = |(irq_status_nxt & irq_enable_r);         // [RULE9] [RULE21]

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      IRQ_REQ     <= 1'b0;
      SYS_ERR_IRQ <= 1'b0;
    end else begin
      IRQ_REQ     <= irq_nxt;                                // [RULE21]
      SYS_ERR_IRQ <= irq_status_nxt[`IRQ_SYS_ERR] & irq_enable_r[`IRQ_SYS_ERR];  // [RULE8]
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always @* begin
    case (REG_ADDR)
      `OFS_IRQ_STATUS: rdata_nxt = irq_status_r;
      `OFS_IRQ_ENABLE: rdata_nxt = irq_enable_r;
      `OFS_ERR_HDR0:   rdata_nxt = hdr_r[0];
      `OFS_ERR_HDR1:   rdata_nxt = hdr_r[1];
      `OFS_ERR_HDR2:   rdata_nxt = hdr_r[2];
      `OFS_ERR_HDR3:   rdata_nxt = hdr_r[3];
      `OFS_ERR_FLAGS:  rdata_nxt = err_flags_r;              // [RULE17]
      `OFS_ERR_ENABLE: rdata_nxt = err_enable_r;
      default:         rdata_nxt = {DATA_W{1'b0}};
    endcase
  end

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      REG_RDATA <= {DATA_W{1'b0}};
    end else if (REG_SEL && !REG_WR) begin
      REG_RDATA <= rdata_nxt;
    end
  end

endmodule // err_irq_ctrl

// ### tb/err_irq_ctrl_sva.sv
// Port assertions for the error interrupt block
`timescale 1ns/10ps
module err_irq_ctrl_sva (
  input wire        REF_CLK,
  input wire        RST_N,
  input wire        REG_SEL,
  input wire        REG_WR,
  input wire [7:0]  REG_ADDR,
  input wire [31:0] REG_RDATA,
  input wire [31:0] SRC_EVENTS,
  input wire [6:0]  ERR_EVENTS,
  input wire        IRQ_REQ,
  input wire        SYS_ERR_IRQ
);
  wire rd_w  = REG_SEL && !REG_WR;
  wire set_w = (|ERR_EVENTS) || SRC_EVENTS[0] || (REG_SEL && REG_WR);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  a_rdata_hold: assert property (!rd_w |=> $stable(REG_RDATA)) else $error("rdata moved");
  a_unmapped_zero: assert property (rd_w && REG_ADDR > 8'h1c |=> !REG_RDATA) else $error("unmapped");
  a_flag_reserved: assert property (rd_w && REG_ADDR == 8'h18 |=> !(REG_RDATA & 32'hfffe_eecc))
    else $error("flag rsv");
  a_erren_reserved: assert property (rd_w && REG_ADDR == 8'h1c |=> !(REG_RDATA & 32'hfffe_eecc))
    else $error("en rsv");
  a_inten_reserved: assert property (rd_w && REG_ADDR == 8'h04 |=> !REG_RDATA[31:27])
    else $error("inten rsv");
  a_sys_in_req: assert property (SYS_ERR_IRQ |-> IRQ_REQ) else $error("sys alone");
  a_sys_cause: assert property ($rose(SYS_ERR_IRQ) |-> $past(set_w) || $past(set_w, 2))
    else $error("sys rose");
  a_quiet_release: assert property ($rose(RST_N) |-> !IRQ_REQ ##1 !SYS_ERR_IRQ) else $error("early");
endmodule // err_irq_ctrl_sva
bind err_irq_ctrl err_irq_ctrl_sva chk_u (.REF_CLK(REF_CLK), .RST_N(RST_N), .REG_SEL(REG_SEL),
  .REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA), .SRC_EVENTS(SRC_EVENTS),
  .ERR_EVENTS(ERR_EVENTS), .IRQ_REQ(IRQ_REQ), .SYS_ERR_IRQ(SYS_ERR_IRQ));

// ### tb/err_event_src.sv
// Error pulse and packet header source model
`timescale 1ns/10ps
module err_event_src (
  input  wire         clk,
  input  wire [7:0]   req,
  input  wire [31:0]  seed,
  output reg  [6:0]   err_ev = 7'h0,
  output reg          pkt_err = 1'h0,
  output reg  [127:0] hdr = 128'h0
);
  // Header lines toggle outside the capture pulse
  always @(negedge clk) begin
    err_ev <= req[6:0];
    pkt_err <= req[7];
    hdr <= req[7] ? {seed + 32'h3, seed + 32'h2, seed + 32'h1, seed} : ~hdr;
  end
endmodule // err_event_src

// ### tb/test_pcie_error_interrupt_logic.sv
// Random and corner stimulus bench for the error interrupt block
`timescale 1ns/10ps
module test_pcie_error_interrupt_logic;
  reg          clk = 0, rst_n = 0, sel = 0, wr = 0, msg_en = 0;
  reg  [7:0]   addr = 8'h0, req = 8'h0;
  reg  [31:0]  wdata = 32'h0, src = 32'h0, r = 32'h0, e = 32'h0;
  wire [31:0]  rdata;
  wire [6:0]   err_ev;
  wire         pkt_err, irq, sys_irq;
  wire [127:0] hdr;
  integer      seed = 18010, miscompares = 0, checks_done = 0, i;
  localparam [34:0] POS = {5'h10, 5'h0c, 5'h08, 5'h05, 5'h04, 5'h01, 5'h00};
  initial forever #50 clk = ~clk;
  err_irq_ctrl dut_u (.REF_CLK(clk), .RST_N(rst_n), .REG_SEL(sel), .REG_WR(wr), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .SRC_EVENTS(src), .MSG_TYPE_EN(msg_en), .PKT_ERR(pkt_err),
    .PKT_HDR_DW0(hdr[31:0]), .PKT_HDR_DW1(hdr[63:32]), .PKT_HDR_DW2(hdr[95:64]),
    .PKT_HDR_DW3(hdr[127:96]), .ERR_EVENTS(err_ev), .IRQ_REQ(irq), .SYS_ERR_IRQ(sys_irq));
  err_event_src src_u (.clk(clk), .req(req), .seed(r), .err_ev(err_ev), .pkt_err(pkt_err), .hdr(hdr));
  task chk(input [47:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task acc(input w, input [7:0] a, input [31:0] d);
    begin
      @(negedge clk);
      {sel, wr, addr, wdata} = {1'b1, w, a, d};
      @(negedge clk);
      sel = 0;
      @(negedge clk);
    end
  endtask
  task fire(input [7:0] v);
    begin
      req <= v;
      @(negedge clk);
      req <= 8'h0;
      repeat (3) @(negedge clk);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1;
    repeat (2) @(negedge clk);
    for (i = 0; i < 9; i = i + 1) begin
      acc(0, 8'(i * 4), 0);
      chk("reset", rdata, 0);
    end
    for (i = 0; i < 5; i = i + 1) begin
      r = i ? $random(seed) : 32'hffff_ffff;
      acc(1, 8'h04, r);
      acc(0, 8'h04, 0);
      chk("inten", rdata, r & 32'h07ff_ffff);
    end
    r = $random(seed);
    fire(8'h80);
    acc(1, 8'h08, ~r);
    for (i = 0; i < 4; i = i + 1) begin
      acc(0, 8'(8 + i * 4), 0);
      chk("header", rdata, r + i);
    end
    acc(1, 8'h04, 32'h1);
    for (i = 0; i < 7; i = i + 1) begin
      e = 32'h1 << POS[i*5 +: 5];
      r = $random(seed) & 32'h0001_1133;
      acc(1, 8'h1c, r);
      fire(8'(1 << i));
      chk("syserr", sys_irq, |(r & e));
      acc(0, 8'h18, 0);
      chk("flags", rdata, e);
      acc(1, 8'h18, e);
      acc(1, 8'h00, 32'h1);
      acc(0, 8'h18, 0);
      chk("clear", rdata | irq, 0);
    end
    acc(1, 8'h04, 32'h20);
    for (i = 0; i < 2; i = i + 1) begin
      msg_en = i[0];
      src = 32'h20;
      @(negedge clk);
      src = 32'h0;
      repeat (2) @(negedge clk);
      chk("msg", irq, i);
    end
    acc(1, 8'h04, 32'h001c_0fc0);
    for (i = 0; i < 2; i = i + 1) begin
      src = i ? 32'h0000_0200 : 32'h0020_0000;
      repeat (2) @(negedge clk);
      chk("level", irq, i);
    end
    src = 32'h0;
    report_and_stop;
  end
endmodule // test_pcie_error_interrupt_logic
